// *** verilog/ssw_station_status.sv ***
// Station status word block: station ID, error flags, word memory, AXI4-Lite.
// Assumes all inputs synchronous to clk_sys_in and a single AXI4-Lite master.
//
// The address map and the AXI4-Lite slave port were decided locally.
`timescale 1ns/1ps
`default_nettype none
module ssw_station_status
  import ssw_pkg::*;
(
  input  wire logic        clk_sys_in,
  input  wire logic        rst_in,
  input  wire logic        station_id_line_1_in,
  input  wire logic        station_id_line_2_in,
  input  wire logic        station_id_line_3_in,
  input  wire logic        station_id_line_4_in,
  input  wire logic        fkey_status_fail_in,
  input  wire logic        host_comm_err_in,
  input  wire logic        estop_key_in,
  input  wire logic [5:0]  fkey_in,
  input  wire logic [7:0]  s_axi_awaddr_in,
  input  wire logic        s_axi_awvalid_in,
  output logic             s_axi_awready_out,
  input  wire logic [31:0] s_axi_wdata_in,
  input  wire logic [3:0]  s_axi_wstrb_in,
  input  wire logic        s_axi_wvalid_in,
  output logic             s_axi_wready_out,
  output logic [1:0]       s_axi_bresp_out,
  output logic             s_axi_bvalid_out,
  input  wire logic        s_axi_bready_in,
  input  wire logic [7:0]  s_axi_araddr_in,
  input  wire logic        s_axi_arvalid_in,
  output logic             s_axi_arready_out,
  output logic [31:0]      s_axi_rdata_out,
  output logic [1:0]       s_axi_rresp_out,
  output logic             s_axi_rvalid_out,
  input  wire logic        s_axi_rready_in,
  output logic             box_connected_out,
  output logic             irq_out
);
  // ****************************************
  // Station sampling and status word
  // ****************************************
  ssw_mem_if mem_if ();
  logic [STN_W-1:0] id_lines;
  logic [STN_W-1:0] stn_w;
  logic             stn_chg;
  logic [15:0]      status_word_reg;
  logic             board_q_reg;
  logic             comm_q_reg;

  assign id_lines = {station_id_line_4_in, station_id_line_3_in,
                     station_id_line_2_in, station_id_line_1_in};

  ssw_id_sampler u_sampler (
    .clk_sys_in  (clk_sys_in),
    .rst_in      (rst_in),
    .lines_in    (id_lines),
    .station_out (stn_w),
    .change_out  (stn_chg)
  );

  ssw_word_mem u_mem (
    .clk_sys_in (clk_sys_in),
    .mem        (mem_if)
  );

  always_ff @(posedge clk_sys_in)
  begin
    if (rst_in)
    begin
      status_word_reg <= 16'h0000;
    end
    else
    begin
      status_word_reg <= {fkey_status_fail_in,
                          host_comm_err_in,
                          10'h000,
                          stn_w};
    end
  end

  // Field value 0 is the "no box" code, not a station
  assign box_connected_out = status_word_reg[STN_W-1:0] != 4'h0;

  // ****************************************
  // Key report, terminal side only
  // ****************************************
  logic [6:0] keys_reg;

  always_ff @(posedge clk_sys_in)
  begin
    if (rst_in)
    begin
      keys_reg <= 7'h00;
    end
    else
    begin
      keys_reg <= {estop_key_in, fkey_in};
    end
  end

  // ****************************************
  // Placement of the word in memory
  // ****************************************
  logic [15:0] cfg_reg;
  logic [15:0] written_reg;
  logic        dirty_reg;
  logic        cfg_legal;
  logic        cfg_wr;
  logic [1:0]  cfg_area;

  assign cfg_area  = cfg_reg[CFG_AREA_LSB +: 2];
  // System area and unused codes are never targets
  assign cfg_legal = cfg_reg[CFG_EN] &&
                     (cfg_area == AREA_USER || cfg_area == AREA_RETAIN);

  assign mem_if.we    = cfg_legal && (dirty_reg || written_reg != status_word_reg);
  assign mem_if.warea = cfg_area[0];
  assign mem_if.waddr = cfg_reg[CFG_IDX_LSB +: MEM_AW];
  assign mem_if.wdata = status_word_reg;

  always_ff @(posedge clk_sys_in)
  begin
    if (rst_in)
    begin
      written_reg <= 16'h0000;
      dirty_reg   <= 1'b1;
    end
    else
    begin
      if (mem_if.we)
      begin
        written_reg <= status_word_reg;
      end
      // A new placement must be filled even if the word is unchanged
      dirty_reg <= cfg_wr || (dirty_reg && !mem_if.we);
    end
  end

  // ****************************************
  // AXI4-Lite write channel
  // ****************************************
  logic        aw_hold_reg;
  logic        w_hold_reg;
  logic [7:0]  awaddr_reg;
  logic [31:0] wdata_reg;
  logic [3:0]  wstrb_reg;
  logic        bvalid_reg;
  logic [1:0]  bresp_reg;
  logic        do_wr;
  logic [7:0]  wofs;
  logic [15:0] irq_en_reg;
  logic [MEM_AW:0] mem_ptr_reg;

  assign s_axi_awready_out = !aw_hold_reg && !bvalid_reg;
  assign s_axi_wready_out  = !w_hold_reg && !bvalid_reg;
  assign s_axi_bvalid_out  = bvalid_reg;
  assign s_axi_bresp_out   = bresp_reg;
  assign do_wr = aw_hold_reg && w_hold_reg && !bvalid_reg;
  assign wofs  = {awaddr_reg[7:2], 2'b00};
  assign cfg_wr = do_wr && wofs == OFS_CFG;

  function automatic logic [15:0] merge(input logic [15:0] old, input logic [31:0] d,
                                        input logic [3:0] s);
    merge = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
  endfunction : merge

  always_ff @(posedge clk_sys_in)
  begin
    if (rst_in)
    begin
      aw_hold_reg <= 1'b0;
      w_hold_reg  <= 1'b0;
      awaddr_reg  <= 8'h00;
      wdata_reg   <= 32'h0000_0000;
      wstrb_reg   <= 4'h0;
      bvalid_reg  <= 1'b0;
      bresp_reg   <= RESP_OKAY;
    end
    else
    begin
      if (s_axi_awvalid_in && s_axi_awready_out)
      begin
        aw_hold_reg <= 1'b1;
        awaddr_reg  <= s_axi_awaddr_in;
      end
      if (s_axi_wvalid_in && s_axi_wready_out)
      begin
        w_hold_reg <= 1'b1;
        wdata_reg  <= s_axi_wdata_in;
        wstrb_reg  <= s_axi_wstrb_in;
      end
      if (do_wr)
      begin
        aw_hold_reg <= 1'b0;
        w_hold_reg  <= 1'b0;
        bvalid_reg  <= 1'b1;
        bresp_reg   <= (wofs == OFS_CFG || wofs == OFS_IRQ_CLR || wofs == OFS_IRQ_EN ||
                        wofs == OFS_MEM_PTR) ? RESP_OKAY : RESP_SLVERR;
      end
      else if (bvalid_reg && s_axi_bready_in)
      begin
        bvalid_reg <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_sys_in)
  begin
    if (rst_in)
    begin
      cfg_reg     <= CFG_RST;
      irq_en_reg  <= 16'h0000;
      mem_ptr_reg <= '0;
    end
    else if (do_wr)
    begin
      if (wofs == OFS_CFG)
      begin
        cfg_reg <= merge(cfg_reg, wdata_reg, wstrb_reg);
      end
      if (wofs == OFS_IRQ_EN)
      begin
        irq_en_reg <= merge(irq_en_reg, wdata_reg, wstrb_reg);
      end
      if (wofs == OFS_MEM_PTR && wstrb_reg[0])
      begin
        mem_ptr_reg <= wdata_reg[MEM_AW:0];
      end
    end
  end

  // ****************************************
  // Interrupts
  // ****************************************
  logic [IRQ_N-1:0] irq_sts_reg;
  logic [IRQ_N-1:0] irq_ev;
  logic [IRQ_N-1:0] irq_clr;

  assign irq_ev[EV_STATION] = stn_chg;
  assign irq_ev[EV_BOARD]   = fkey_status_fail_in && !board_q_reg;
  assign irq_ev[EV_COMM]    = host_comm_err_in && !comm_q_reg;
  assign irq_ev[EV_REFUSED] = cfg_wr && wstrb_reg[0] && wdata_reg[CFG_EN] &&
                              wdata_reg[CFG_AREA_LSB + 1];
  assign irq_clr = (do_wr && wofs == OFS_IRQ_CLR) ? wdata_reg[IRQ_N-1:0] : '0;

  // Set wins over a clear landing in the same cycle
  always_ff @(posedge clk_sys_in)
  begin
    if (rst_in)
    begin
      irq_sts_reg <= '0;
      board_q_reg <= 1'b0;
      comm_q_reg  <= 1'b0;
    end
    else
    begin
      irq_sts_reg <= (irq_sts_reg & ~irq_clr) | irq_ev;
      board_q_reg <= fkey_status_fail_in;
      comm_q_reg  <= host_comm_err_in;
    end
  end

  assign irq_out = |(irq_sts_reg & irq_en_reg[IRQ_N-1:0]);

  // ****************************************
  // AXI4-Lite read channel
  // ****************************************
  logic        rvalid_reg;
  logic [31:0] rdata_reg;
  logic [1:0]  rresp_reg;
  logic [7:0]  rofs;

  assign s_axi_arready_out = !rvalid_reg;
  assign s_axi_rvalid_out  = rvalid_reg;
  assign s_axi_rdata_out   = rdata_reg;
  assign s_axi_rresp_out   = rresp_reg;
  assign rofs         = {s_axi_araddr_in[7:2], 2'b00};
  assign mem_if.rarea = mem_ptr_reg[MEM_AW];
  assign mem_if.raddr = mem_ptr_reg[MEM_AW-1:0];

  always_ff @(posedge clk_sys_in)
  begin
    if (rst_in)
    begin
      rvalid_reg <= 1'b0;
      rdata_reg  <= 32'h0000_0000;
      rresp_reg  <= RESP_OKAY;
    end
    else if (s_axi_arvalid_in && s_axi_arready_out)
    begin
      rvalid_reg <= 1'b1;
      rresp_reg  <= RESP_OKAY;
      unique case (rofs)
        OFS_STATUS:  rdata_reg <= {16'h0000, status_word_reg};
        OFS_CFG:     rdata_reg <= {16'h0000, cfg_reg};
        OFS_KEYS:    rdata_reg <= {25'h0000000, keys_reg};
        OFS_IRQ_STS: rdata_reg <= {28'h0000000, irq_sts_reg};
        OFS_IRQ_EN:  rdata_reg <= {16'h0000, irq_en_reg};
        OFS_MEM_PTR: rdata_reg <= {25'h0000000, mem_ptr_reg};
        OFS_MEM_DAT: rdata_reg <= {16'h0000, mem_if.rdata};
        default:
        begin
          rdata_reg <= 32'h0000_0000;
          rresp_reg <= RESP_SLVERR;
        end
      endcase
    end
    else if (rvalid_reg && s_axi_rready_in)
    begin
      rvalid_reg <= 1'b0;
    end
  end

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (rst_in);

  AST_ID_ORDER: assert property (stn_chg |=> status_word_reg[3:0] == $past(stn_w))
    else $error("station field not taken from sampler");
  AST_NO_BOX: assert property (!rst_in |=> box_connected_out == ($past(stn_w) != 4'h0))
    else $error("box flag disagrees with station field");
  AST_BOARD_ERR: assert property (!rst_in |=> status_word_reg[BIT_BOARD] == $past(fkey_status_fail_in))
    else $error("board error bit wrong");
  AST_COMM_ERR: assert property (!rst_in |=> status_word_reg[BIT_COMM] == $past(host_comm_err_in))
    else $error("comm error bit wrong");
  AST_ONE_WORD: assert property (mem_if.we |=> written_reg == $past(status_word_reg))
    else $error("written word differs from status word");
  AST_LEGAL_AREA: assert property (mem_if.we |-> !cfg_area[1])
    else $error("write to system area");
  AST_UNSET: assert property (!cfg_reg[CFG_EN] |-> !mem_if.we)
    else $error("write with no placement set");
  AST_REFLECT: assert property ((cfg_legal && $stable(cfg_reg) && written_reg != status_word_reg)
    |-> ##[0:1] mem_if.we)
    else $error("new station not written");
  AST_KEYS: assert property (!rst_in |=> keys_reg == $past({estop_key_in, fkey_in}))
    else $error("key report stale");
  AST_RESERVED: assert property (mem_if.we |-> mem_if.wdata[13:4] == 10'h000)
    else $error("reserved bits not zero");
endmodule : ssw_station_status
`default_nettype wire

// *** shared/ssw_pkg.sv ***
// Constants for the station status word block.
// Assumes a 250 MHz system clock and an AXI4-Lite register port.
package ssw_pkg;
  // ****************************************
  // Timing
  // ****************************************
  localparam int CLK_NS     = 4;
  localparam int SETTLE_NS  = 1000;
  localparam int SETTLE_CYC = (SETTLE_NS + CLK_NS - 1) / CLK_NS;
  localparam int CNT_W      = $clog2(SETTLE_CYC + 1);
  // ****************************************
  // Register offsets (byte addresses)
  // ****************************************
  localparam logic [7:0] OFS_STATUS  = 8'h00;
  localparam logic [7:0] OFS_CFG     = 8'h04;
  localparam logic [7:0] OFS_KEYS    = 8'h08;
  localparam logic [7:0] OFS_IRQ_STS = 8'h0c;
  localparam logic [7:0] OFS_IRQ_CLR = 8'h10;
  localparam logic [7:0] OFS_IRQ_EN  = 8'h14;
  localparam logic [7:0] OFS_MEM_PTR = 8'h18;
  localparam logic [7:0] OFS_MEM_DAT = 8'h1c;
  // ****************************************
  // Fields
  // ****************************************
  localparam int STN_W        = 4;
  localparam int BIT_BOARD    = 15;
  localparam int BIT_COMM     = 14;
  localparam int CFG_EN       = 0;
  localparam int CFG_AREA_LSB = 1;
  localparam int CFG_IDX_LSB  = 8;
  localparam int MEM_AW       = 6;
  localparam int IRQ_N        = 4;
  localparam int EV_STATION   = 0;
  localparam int EV_BOARD     = 1;
  localparam int EV_COMM      = 2;
  localparam int EV_REFUSED   = 3;
  localparam logic [1:0] AREA_USER   = 2'h0;
  localparam logic [1:0] AREA_RETAIN = 2'h1;
  localparam logic [15:0] CFG_RST    = 16'h0000;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : ssw_pkg

// *** shared/ssw_mem_if.sv ***
// Port between the status block and its internal word memory.
// Assumes one writer and one reader, same clock.
`timescale 1ns/1ps
`default_nettype none
interface ssw_mem_if;
  logic        we;
  logic        warea;
  logic [5:0]  waddr;
  logic [15:0] wdata;
  logic        rarea;
  logic [5:0]  raddr;
  logic [15:0] rdata;
  modport host (output we, warea, waddr, wdata, rarea, raddr, input rdata);
  modport mem  (input we, warea, waddr, wdata, rarea, raddr, output rdata);
endinterface : ssw_mem_if
`default_nettype wire

// *** verilog/ssw_word_mem.sv ***
// Internal memory: user word area and retained word area.
// Assumes a single clock; contents are not reset.
`timescale 1ns/1ps
`default_nettype none
module ssw_word_mem
  import ssw_pkg::*;
(
  input  wire logic clk_sys_in,
  ssw_mem_if.mem    mem
);
  logic [15:0] words [0:(2 << MEM_AW) - 1];

  always_ff @(posedge clk_sys_in)
  begin
    if (mem.we)
    begin
      words[{mem.warea, mem.waddr}] <= mem.wdata;
    end
  end

  assign mem.rdata = words[{mem.rarea, mem.raddr}];
endmodule : ssw_word_mem
`default_nettype wire

// *** verilog/ssw_id_sampler.sv ***
// Samples the four station ID lines and accepts a value once settled.
// Assumes the lines are synchronous to the clock.
`timescale 1ns/1ps
`default_nettype none
module ssw_id_sampler
  import ssw_pkg::*;
(
  input  wire logic             clk_sys_in,
  input  wire logic             rst_in,
  input  wire logic [STN_W-1:0] lines_in,
  output logic      [STN_W-1:0] station_out,
  output logic                  change_out
);
  logic [STN_W-1:0] cand_reg;
  logic [CNT_W-1:0] cnt_reg;
  logic [STN_W-1:0] stn_reg;
  logic             chg_reg;

  // Switch contacts bounce while a box is plugged; wait for a quiet spell
  always_ff @(posedge clk_sys_in)
  begin
    if (rst_in)
    begin
      cand_reg <= 4'h0;
      cnt_reg  <= '0;
      stn_reg  <= 4'h0;
      chg_reg  <= 1'b0;
    end
    else
    begin
      chg_reg <= 1'b0;
      if (lines_in != cand_reg)
      begin
        cand_reg <= lines_in;
        cnt_reg  <= '0;
      end
      else if (cnt_reg != CNT_W'(SETTLE_CYC - 1))
      begin
        cnt_reg <= cnt_reg + CNT_W'(1);
      end
      else if (stn_reg != cand_reg)
      begin
        stn_reg <= cand_reg;
        chg_reg <= 1'b1;
      end
    end
  end

  assign station_out = stn_reg;
  assign change_out  = chg_reg;

  AST_SETTLED: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    chg_reg |-> stn_reg == cand_reg && stn_reg != $past(stn_reg))
    else $error("station accepted without settling");
endmodule : ssw_id_sampler
`default_nettype wire

// *** sim/ssw_box_model.sv ***
// Junction box model: rotary station switch driving four ID lines.
// Assumes pull-downs in the terminal hold the lines low when unplugged.
`timescale 1ns/1ps
`default_nettype none
module ssw_box_model
(
  input  wire logic       plugged_in,
  input  wire logic [3:0] switch_in,
  output logic      [3:0] lines_out
);
  // Position 0 drives no line and reads as no box
  assign lines_out = plugged_in ? switch_in : 4'h0;
endmodule : ssw_box_model
`default_nettype wire

// *** sim/test_ssw_station_status.sv ***
// Testbench for the station status word block.
// Assumes AXI4-Lite timing as handed over and a passive box model.
`timescale 1ns/1ps
`default_nettype none
module test_ssw_station_status
  import ssw_pkg::*;
;
  logic        clk_sys_in, rst_in, fail, comm, estop, plugged;
  logic        awvalid, wvalid, bready, arvalid, rready;
  logic        awready, wready, bvalid, arready, rvalid, box_conn, irq;
  logic [5:0]  fkey;
  logic [3:0]  sw, lines;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata, rd;
  logic [1:0]  bresp, rresp, rs;
  int          err_total, samples_checked;

  // One terminal on this port only
  ssw_box_model box (.plugged_in(plugged), .switch_in(sw), .lines_out(lines));

  ssw_station_status uut (
    .clk_sys_in(clk_sys_in), .rst_in(rst_in),
    .station_id_line_1_in(lines[0]), .station_id_line_2_in(lines[1]),
    .station_id_line_3_in(lines[2]), .station_id_line_4_in(lines[3]),
    .fkey_status_fail_in(fail), .host_comm_err_in(comm), .estop_key_in(estop), .fkey_in(fkey),
    .s_axi_awaddr_in(awaddr), .s_axi_awvalid_in(awvalid), .s_axi_awready_out(awready),
    .s_axi_wdata_in(wdata), .s_axi_wstrb_in(4'hf), .s_axi_wvalid_in(wvalid),
    .s_axi_wready_out(wready), .s_axi_bresp_out(bresp), .s_axi_bvalid_out(bvalid),
    .s_axi_bready_in(bready), .s_axi_araddr_in(araddr), .s_axi_arvalid_in(arvalid),
    .s_axi_arready_out(arready), .s_axi_rdata_out(rdata), .s_axi_rresp_out(rresp),
    .s_axi_rvalid_out(rvalid), .s_axi_rready_in(rready),
    .box_connected_out(box_conn), .irq_out(irq));

  initial
  begin
    clk_sys_in = 1'b0;
    forever #2 clk_sys_in = ~clk_sys_in;
  end

  // ****************************************
  // Bus tasks
  // ****************************************
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      err_total++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  // Both channels offered together, each released once taken
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    logic ta, tw;
    ta = 1'b0;
    tw = 1'b0;
    awaddr  <= a;
    wdata   <= d;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    while (!(ta && tw))
    begin
      @(posedge clk_sys_in);
      if (!ta && awready === 1'b1)
      begin
        ta = 1'b1;
        awvalid <= 1'b0;
      end
      if (!tw && wready === 1'b1)
      begin
        tw = 1'b1;
        wvalid <= 1'b0;
      end
    end
    do @(posedge clk_sys_in); while (bvalid !== 1'b1);
    r = bresp;
    bready <= 1'b0;
    @(posedge clk_sys_in);
  endtask : axi_wr

  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do @(posedge clk_sys_in); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge clk_sys_in); while (rvalid !== 1'b1);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
    @(posedge clk_sys_in);
  endtask : axi_rd

  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    axi_rd(a, rd, rs);
    chk(rd, exp);
    chk({30'h0, rs}, {30'h0, RESP_OKAY});
  endtask : rdc

  task automatic wrc(input logic [7:0] a, input logic [31:0] d, input logic [1:0] exp);
    axi_wr(a, d, rs);
    chk({30'h0, rs}, {30'h0, exp});
  endtask : wrc

  // Lines must hold for the settle time before the word follows
  task automatic settle;
    repeat (SETTLE_CYC + 8) @(posedge clk_sys_in);
  endtask : settle

  task automatic results;
    if (err_total == 0 && samples_checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : results

  // Whole run is near 5000 cycles, so this only cuts a hang
  initial
  begin
    repeat (50000) @(posedge clk_sys_in);
    err_total++;
    results();
  end

  // ****************************************
  // Tests
  // ****************************************
  initial
  begin
    err_total = 0;
    samples_checked = 0;
    rst_in = 1'b1;
    {fail, comm, estop, plugged, awvalid, wvalid, bready, arvalid, rready} = 9'h0;
    {fkey, sw, awaddr, araddr, wdata} = 58'h0;
    repeat (12) @(posedge clk_sys_in);
    rst_in <= 1'b0;
    @(posedge clk_sys_in);
    rdc(OFS_STATUS, 32'h0);
    rdc(OFS_CFG, 32'h0);
    chk({31'h0, irq}, 32'h0);
    wrc(OFS_CFG, 32'h0501, RESP_OKAY);
    wrc(OFS_MEM_PTR, 32'h05, RESP_OKAY);
    plugged <= 1'b1;
    for (int n = 0; n < 16; n++)
    begin
      sw <= 4'(n);
      settle();
      rdc(OFS_STATUS, 32'(n));
      chk({31'h0, box_conn}, {31'h0, n != 0});
      rdc(OFS_MEM_DAT, 32'(n));
    end
    plugged <= 1'b0;
    settle();
    rdc(OFS_STATUS, 32'h0);
    rdc(OFS_IRQ_STS, 32'h1);
    wrc(OFS_IRQ_CLR, 32'hf, RESP_OKAY);
    rdc(OFS_IRQ_STS, 32'h0);
    wrc(OFS_IRQ_EN, 32'h2, RESP_OKAY);
    fail <= 1'b1;
    repeat (4) @(posedge clk_sys_in);
    chk({31'h0, irq}, 32'h1);
    rdc(OFS_STATUS, 32'h8000);
    wrc(OFS_IRQ_EN, 32'h0, RESP_OKAY);
    chk({31'h0, irq}, 32'h0);
    wrc(OFS_IRQ_CLR, 32'h2, RESP_OKAY);
    rdc(OFS_IRQ_STS, 32'h0);
    comm <= 1'b1;
    repeat (4) @(posedge clk_sys_in);
    rdc(OFS_STATUS, 32'hc000);
    rdc(OFS_MEM_DAT, 32'hc000);
    rdc(OFS_IRQ_STS, 32'h4);
    fail <= 1'b0;
    plugged <= 1'b1;
    settle();
    rdc(OFS_STATUS, 32'h400f);
    wrc(OFS_CFG, 32'h0703, RESP_OKAY);
    wrc(OFS_MEM_PTR, 32'h47, RESP_OKAY);
    rdc(OFS_MEM_DAT, 32'h400f);
    rdc(OFS_CFG, 32'h0703);
    wrc(OFS_IRQ_CLR, 32'hf, RESP_OKAY);
    wrc(OFS_CFG, 32'h0705, RESP_OKAY);
    rdc(OFS_IRQ_STS, 32'h8);
    fkey <= 6'h2d;
    estop <= 1'b1;
    repeat (2) @(posedge clk_sys_in);
    rdc(OFS_KEYS, 32'h6d);
    fkey <= 6'h12;
    estop <= 1'b0;
    repeat (2) @(posedge clk_sys_in);
    rdc(OFS_KEYS, 32'h12);
    axi_rd(8'h20, rd, rs);
    chk(rd, 32'h0);
    chk({30'h0, rs}, {30'h0, RESP_SLVERR});
    wrc(OFS_STATUS, 32'h5, RESP_SLVERR);
    wrc(8'h20, 32'h1, RESP_SLVERR);
    rdc(OFS_STATUS, 32'h400f);
    comm <= 1'b0;
    rst_in <= 1'b1;
    repeat (12) @(posedge clk_sys_in);
    rst_in <= 1'b0;
    @(posedge clk_sys_in);
    rdc(OFS_CFG, 32'h0);
    rdc(OFS_STATUS, 32'h0);
    results();
  end
endmodule : test_ssw_station_status
`default_nettype wire
